// [core/adcsq_pkg.sv]
// Function
// - the fourth sequencer runs a programme of exactly one step.
// - comparator on a sequence's final step fires nothing unless trigger-always mode.
// - result of step n goes to the comparator of step n+1, using its settings.
// - arbiter starts the pending sequencer with lowest priority value; 0 highest.
// - with only third and fourth pending, second and third priorities are compared.
// - no sampling when main or precision oscillator clocks both system and converter.
// - first two samples after converter clock enable are suspect; soft reset clears that.
// - phase offset delays sampling from each sequencer's own trigger instant.
// - with sync-wait set, processor triggers are held and released together by global-sync.
// - trigger-always mode applies no phase offset alignment.
// - the noise spread bit has no effect on conversion.
package adcsq_pkg;
  localparam int         SEQ_N        = 4;
  localparam int         STEP_N       = 8;
  localparam int         RES_W        = 12;
  localparam int         PRIO_W       = 2;
  localparam int         STEP_W       = 3;
  localparam int         PHASE_W      = 4;
  localparam logic [1:0] WARM_SAMPLES = 2'h2;
  localparam logic [2:0] SEQ3_LAST    = 3'h0;
  localparam logic [3:0] TAIL_PAIR    = 4'hc;

  typedef enum logic [1:0] {ADCSQ_CLK_PLL, ADCSQ_CLK_MAIN_OSCILLATOR, ADCSQ_CLK_PRECISION_INTERNAL_OSCILLATOR} adcsq_clk_t;
endpackage

// [core/adcsq_cmp_if.sv]
`timescale 1ns/1ps
interface adcsq_cmp_if;
  import adcsq_pkg::*;
  logic [RES_W-1:0] result;
  logic             strobe;
  logic             enable;
  logic             above;
  logic [RES_W-1:0] threshold;
  logic             hit;

  modport ctrl (output result, output strobe, output enable, output above, output threshold, input hit);
  modport cmp  (input result, input strobe, input enable, input above, input threshold, output hit);
endinterface

// [core/adcsq_cmp.sv]
`timescale 1ns/1ps
module adcsq_cmp
(
  input  wire logic  ref_clk,
  input  wire logic  resetn,
  input  wire logic  clk_en,
  adcsq_cmp_if.cmp   cif
);
  import adcsq_pkg::*;

  wire match;

  // comparator applies its own settings to whatever result it is handed
  assign match = cif.above ? (cif.result >= cif.threshold) : (cif.result < cif.threshold);

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      cif.hit <= 1'b0;
    else if (clk_en)
      cif.hit <= cif.strobe & cif.enable & match;
  end
endmodule

// [core/adcsq_control.sv]
`timescale 1ns/1ps
module adcsq_control
(
  input  wire logic                                           ref_clk,
  input  wire logic                                           resetn,
  input  wire logic                                           clk_en,
  input  wire logic [adcsq_pkg::SEQ_N-1:0]                    trig_req,
  input  wire logic [adcsq_pkg::SEQ_N-1:0]                    trigger_always,
  input  wire logic [adcsq_pkg::SEQ_N-1:0]                    proc_initiate,
  input  wire logic                                           sync_wait_bit,
  input  wire logic                                           global_sync_bit,
  input  wire logic [adcsq_pkg::SEQ_N-1:0][adcsq_pkg::PRIO_W-1:0] seq_priority,
  input  wire logic [adcsq_pkg::SEQ_N-1:0][adcsq_pkg::STEP_W-1:0] seq_last_step,
  input  wire logic [adcsq_pkg::PHASE_W-1:0]                  phase_offset,
  input  wire adcsq_pkg::adcsq_clk_t                          sys_clk_src,
  input  wire adcsq_pkg::adcsq_clk_t                          conv_clk_src,
  input  wire logic                                           converter_clock_gate,
  input  wire logic                                           converter_soft_reset,
  input  wire logic                                           noise_spread_bit,
  input  wire logic [adcsq_pkg::STEP_N-1:0]                   cmp_enable,
  input  wire logic [adcsq_pkg::STEP_N-1:0]                   cmp_above,
  input  wire logic [adcsq_pkg::RES_W-1:0]                    cmp_threshold,
  input  wire logic                                           conv_done,
  input  wire logic [adcsq_pkg::RES_W-1:0]                    conv_result,
  output logic                                                conv_start,
  output logic [1:0]                                          conv_seq,
  output logic [adcsq_pkg::STEP_W-1:0]                        conv_step,
  output logic                                                result_valid,
  output logic [adcsq_pkg::RES_W-1:0]                         result_data,
  output logic [1:0]                                          result_seq,
  output logic [adcsq_pkg::STEP_W-1:0]                        result_step,
  output logic                                                result_suspect,
  output logic [adcsq_pkg::STEP_N-1:0]                        cmp_event,
  output logic [adcsq_pkg::SEQ_N-1:0]                         seq_busy,
  output logic                                                seq_end,
  output logic                                                sampling_stalled
);
  import adcsq_pkg::*;

  typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_START, ADCSQ_WAIT} adcsq_state_t;

  adcsq_state_t            st;
  logic [SEQ_N-1:0]        pending;
  logic [SEQ_N-1:0]        next_pending;
  logic [SEQ_N-1:0]        proc_hold;
  logic [SEQ_N-1:0]        dly_run;
  logic [SEQ_N-1:0]        set_pend;
  logic [SEQ_N-1:0][PHASE_W-1:0] dly;
  logic [1:0]              cur_seq;
  logic [STEP_W-1:0]       cur_step;
  logic [STEP_W-1:0]       cur_last;
  logic                    cur_always;
  logic [1:0]              warm;
  logic                    gate_q;
  logic [1:0]              pick_norm;
  logic [PRIO_W-1:0]       best;
  logic                    found;
  logic [STEP_N-1:0]       strobe_vec;
  logic [STEP_N-1:0]       hits;

  wire       rst_all     = !resetn || converter_soft_reset;
  wire       sampling_ok = !((sys_clk_src == conv_clk_src) &&
                             (sys_clk_src == ADCSQ_CLK_MAIN_OSCILLATOR || sys_clk_src == ADCSQ_CLK_PRECISION_INTERNAL_OSCILLATOR));
  wire       tail_only   = (pending == TAIL_PAIR);
  wire [1:0] pick_tail   = (seq_priority[1] < seq_priority[2]) ? 2'h2 : 2'h3;
  wire [1:0] pick        = tail_only ? pick_tail : pick_norm;
  wire       grant       = (st == ADCSQ_IDLE) && (|pending);
  wire [STEP_W-1:0] grant_last = (pick == 2'h3) ? SEQ3_LAST : seq_last_step[pick];
  wire       done_now    = (st == ADCSQ_WAIT) && conv_done;
  wire [3:0] cmp_idx     = {1'b0, cur_step} + 4'h1;
  wire       last_quiet  = (cmp_idx == {1'b0, cur_last}) && !cur_always;
  wire       warm_rise   = converter_clock_gate && !gate_q;
  wire       noise_unused = noise_spread_bit;  // no effect on conversion

  // lowest priority value wins, ties to the lower sequencer
  always_comb
  begin
    pick_norm = 2'h0;
    best      = '1;
    found     = 1'b0;
    for (int i = 0; i < SEQ_N; i++)
    begin
      if (pending[i] && (!found || seq_priority[i] < best))
      begin
        pick_norm = 2'(i);
        best      = seq_priority[i];
        found     = 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < SEQ_N; g++)
    begin : g_seq
      wire proc_now  = proc_initiate[g] && !sync_wait_bit;
      wire proc_rel  = proc_hold[g] && global_sync_bit;
      wire trig      = trig_req[g] || proc_now || proc_rel;
      wire idle_self = !(st != ADCSQ_IDLE && cur_seq == 2'(g));
      // offset counts from this sequencer's own trigger; no shared reference
      assign set_pend[g] = trigger_always[g] ? (!pending[g] && idle_self) :
                           ((trig && phase_offset == '0) || (dly_run[g] && dly[g] == 4'h1));
      assign next_pending[g] = set_pend[g] || (pending[g] && !(grant && pick == 2'(g)));

      always_ff @(posedge ref_clk)
      begin
        if (rst_all)
        begin
          proc_hold[g] <= 1'b0;
          dly_run[g]   <= 1'b0;
          dly[g]       <= '0;
        end
        else if (clk_en)
        begin
          proc_hold[g] <= (proc_initiate[g] && sync_wait_bit) || (proc_hold[g] && !global_sync_bit);
          if (trig && !trigger_always[g] && phase_offset != '0)
          begin
            dly_run[g] <= 1'b1;
            dly[g]     <= phase_offset;
          end
          else if (dly_run[g])
          begin
            dly[g]     <= dly[g] - 4'h1;
            dly_run[g] <= (dly[g] != 4'h1);
          end
        end
      end
    end
  endgenerate

  adcsq_cmp_if cif[STEP_N] ();

  generate
    for (g = 0; g < STEP_N; g++)
    begin : g_cmp
      assign strobe_vec[g]    = done_now && (cmp_idx == 4'(g)) && !last_quiet;
      assign cif[g].strobe    = strobe_vec[g];
      assign cif[g].result    = conv_result;
      assign cif[g].enable    = cmp_enable[g];
      assign cif[g].above     = cmp_above[g];
      assign cif[g].threshold = cmp_threshold;
      assign hits[g]          = cif[g].hit;
      adcsq_cmp u_cmp (.ref_clk(ref_clk), .resetn(!rst_all), .clk_en(clk_en), .cif(cif[g]));
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      gate_q <= 1'b0;
    else if (clk_en)
      gate_q <= converter_clock_gate;
  end

  // converter core sits on ref_clk, so conv_done needs no synchroniser
  always_ff @(posedge ref_clk)
  begin
    if (rst_all)
    begin
      st <= ADCSQ_IDLE;
      pending <= '0;
      cur_seq <= 2'h0;
      cur_step <= '0;
      cur_last <= '0;
      cur_always <= 1'b0;
      warm <= 2'h0;
      conv_start <= 1'b0;
      conv_seq <= 2'h0;
      conv_step <= '0;
      result_valid <= 1'b0;
      result_data <= '0;
      result_seq <= 2'h0;
      result_step <= '0;
      result_suspect <= 1'b0;
      cmp_event <= '0;
      seq_busy <= '0;
      seq_end <= 1'b0;
      sampling_stalled <= 1'b0;
    end
    else if (clk_en)
    begin
      pending <= next_pending;
      cmp_event <= hits;
      conv_start <= 1'b0;
      result_valid <= 1'b0;
      seq_end <= 1'b0;
      if (warm_rise)
        warm <= WARM_SAMPLES;
      else if (done_now && warm != 2'h0)
        warm <= warm - 2'h1;
      case (st)
        ADCSQ_IDLE:
        begin
          sampling_stalled <= 1'b0;
          if (grant)
          begin
            cur_seq <= pick;
            cur_step <= '0;
            cur_last <= grant_last;
            cur_always <= trigger_always[pick];
            seq_busy <= 4'(1) << pick;
            st <= ADCSQ_START;
          end
        end
        ADCSQ_START:
        begin
          // a bad clock pairing stalls here rather than aborting the sequence
          sampling_stalled <= !sampling_ok;
          if (sampling_ok)
          begin
            conv_start <= 1'b1;
            conv_seq <= cur_seq;
            conv_step <= cur_step;
            st <= ADCSQ_WAIT;
          end
        end
        ADCSQ_WAIT:
        begin
          if (conv_done)
          begin
            result_valid <= 1'b1;
            result_data <= conv_result;
            result_seq <= cur_seq;
            result_step <= cur_step;
            result_suspect <= (warm != 2'h0);
            if (cur_step == cur_last)
            begin
              st <= ADCSQ_IDLE;
              seq_busy <= '0;
              seq_end <= 1'b1;
            end
            else
            begin
              cur_step <= cur_step + 3'h1;
              st <= ADCSQ_START;
            end
          end
        end
        default:
          st <= ADCSQ_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst_all || !clk_en);

  chk_seq3_single: assert property (conv_start && conv_seq == 2'h3 |-> conv_step == 3'h0)
    else $error("fourth sequencer ran beyond one step");
  // looks through the comparator flop and the output flop, not at the gating term
  chk_last_quiet: assert property (done_now && cmp_idx == {1'b0, cur_last} && !cur_always
                                   |-> ##2 cmp_event == '0)
    else $error("final step comparator was fed");
  chk_cmp_shift: assert property (done_now && !last_quiet && !cmp_idx[3]
                                  |-> strobe_vec == (8'h01 << cmp_idx[2:0]))
    else $error("result not routed to next step comparator");
  chk_lowest_wins: assert property (st == ADCSQ_IDLE && pending == 4'h3 && seq_priority[0] < seq_priority[1]
                                    |=> cur_seq == 2'h0 && st == ADCSQ_START)
    else $error("lower priority value not chosen");
  chk_tail_swap: assert property (st == ADCSQ_IDLE && pending == TAIL_PAIR && seq_priority[1] < seq_priority[2]
                                  |=> cur_seq == 2'h2)
    else $error("tail pair arbitration differs");
  chk_clk_stall: assert property (st == ADCSQ_START && !sampling_ok |=> !conv_start && sampling_stalled)
    else $error("sampled with forbidden clock pairing");
  chk_warm_flag: assert property (done_now && warm != 2'h0 |=> result_valid && result_suspect)
    else $error("early sample not flagged");
  chk_sync_hold: assert property (proc_initiate[0] && sync_wait_bit && !global_sync_bit |=> proc_hold[0])
    else $error("held processor trigger lost");
  chk_step_order: assert property (done_now && cur_step != cur_last |=> cur_step == $past(cur_step) + 3'h1)
    else $error("steps not in order");
  chk_no_regrant: assert property (st == ADCSQ_WAIT && !conv_done |=> $stable(cur_seq))
    else $error("sequencer switched mid sequence");

  cov_tail_pair: cover property (st == ADCSQ_IDLE && pending == TAIL_PAIR);
  cov_seq_end: cover property (seq_end && result_seq == 2'h3);
  cov_stall: cover property (sampling_stalled);
endmodule

// [verification/adcsq_core_model.sv]
`timescale 1ns/1ps
module adcsq_core_model
(
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  input  wire logic                         slow,
  input  wire logic                         conv_start,
  input  wire logic [1:0]                   conv_seq,
  input  wire logic [adcsq_pkg::STEP_W-1:0] conv_step,
  output logic                              conv_done,
  output logic [adcsq_pkg::RES_W-1:0]       conv_result
);
  import adcsq_pkg::*;
  logic [2:0] cnt;
  logic [4:0] tag;
  // between answers the result bus toggles, so a stale sample never matches
  always_ff @(posedge ref_clk)
  begin
    conv_done <= 1'b0;
    if (!resetn)
    begin
      cnt         <= 3'h0;
      conv_result <= 12'h000;
    end
    else if (conv_start)
    begin
      cnt         <= slow ? 3'h5 : 3'h1;
      tag         <= {conv_seq, conv_step};
      conv_result <= ~conv_result;
    end
    else if (cnt == 3'h1)
    begin
      cnt         <= 3'h0;
      conv_done   <= 1'b1;
      conv_result <= {tag, 7'h15};
    end
    else
    begin
      cnt         <= (cnt == 3'h0) ? 3'h0 : cnt - 3'h1;
      conv_result <= ~conv_result;
    end
  end
endmodule

// [verification/test_adc_sequencer_control.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module test_adc_sequencer_control;
  import adcsq_pkg::*;
  logic             ref_clk = 1'b0;
  logic             resetn, clk_en, sync_wait_bit, global_sync_bit, slow;
  logic             converter_clock_gate, converter_soft_reset, noise_spread_bit;
  logic [3:0]       trig_req, trigger_always, proc_initiate, phase_offset, seq_busy;
  logic [7:0]       seq_priority, cmp_enable, cmp_above, cmp_event, evs;
  logic [11:0]      seq_last_step, cmp_threshold, conv_result, result_data;
  adcsq_clk_t       sys_clk_src, conv_clk_src;
  logic             conv_done, conv_start, result_valid, result_suspect, seq_end, sampling_stalled;
  logic [1:0]       conv_seq, result_seq;
  logic [2:0]       conv_step, result_step;
  logic [4:0]       sq[$];
  int               sc[$];
  int               cyc, t0, lat0, lat4, nres, sus, miscompares, comparisons;
  adcsq_clk_t       pair_sys[4]  = '{ADCSQ_CLK_MAIN_OSCILLATOR, ADCSQ_CLK_PRECISION_INTERNAL_OSCILLATOR, ADCSQ_CLK_MAIN_OSCILLATOR, ADCSQ_CLK_PLL};
  adcsq_clk_t       pair_conv[4] = '{ADCSQ_CLK_MAIN_OSCILLATOR, ADCSQ_CLK_PRECISION_INTERNAL_OSCILLATOR, ADCSQ_CLK_PRECISION_INTERNAL_OSCILLATOR, ADCSQ_CLK_PRECISION_INTERNAL_OSCILLATOR};
  logic [3:0]       pair_stall   = 4'h3;

  always #4 ref_clk = ~ref_clk;

  adcsq_control i_dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .trig_req(trig_req),
    .trigger_always(trigger_always), .proc_initiate(proc_initiate), .sync_wait_bit(sync_wait_bit),
    .global_sync_bit(global_sync_bit), .seq_priority(seq_priority), .seq_last_step(seq_last_step),
    .phase_offset(phase_offset), .sys_clk_src(sys_clk_src), .conv_clk_src(conv_clk_src),
    .converter_clock_gate(converter_clock_gate), .converter_soft_reset(converter_soft_reset),
    .noise_spread_bit(noise_spread_bit), .cmp_enable(cmp_enable), .cmp_above(cmp_above),
    .cmp_threshold(cmp_threshold), .conv_done(conv_done), .conv_result(conv_result),
    .conv_start(conv_start), .conv_seq(conv_seq), .conv_step(conv_step), .result_valid(result_valid),
    .result_data(result_data), .result_seq(result_seq), .result_step(result_step),
    .result_suspect(result_suspect), .cmp_event(cmp_event), .seq_busy(seq_busy), .seq_end(seq_end),
    .sampling_stalled(sampling_stalled));

  adcsq_core_model i_core (.ref_clk(ref_clk), .resetn(resetn), .slow(slow), .conv_start(conv_start),
    .conv_seq(conv_seq), .conv_step(conv_step), .conv_done(conv_done), .conv_result(conv_result));

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // monitor at the falling edge, away from the edge the bench drives on
  always @(negedge ref_clk)
  begin
    evs = evs | cmp_event;
    if (conv_start)
    begin
      sq.push_back({conv_seq, conv_step});
      sc.push_back(cyc);
    end
    if (result_valid)
    begin
      nres++;
      sus = sus + result_suspect;
      `CHK(result_data, {result_seq, result_step, 7'h15})
    end
  end

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic clear();
    @(posedge ref_clk);
    sq.delete();
    sc.delete();
    evs = 8'h00;
    nres = 0;
    sus = 0;
  endtask

  task automatic trig(input logic [3:0] m);
    @(posedge ref_clk);
    trig_req <= m;
    t0 = cyc;
    @(posedge ref_clk);
    trig_req <= 4'h0;
  endtask

  task automatic expect_order(input logic [29:0] exp, input int n);
    `CHK(sq.size(), n)
    for (int i = 0; i < n; i++)
      `CHK(sq[i], exp[5*(n-1-i) +: 5])
  endtask

  initial
  begin
    {resetn, clk_en, sync_wait_bit, global_sync_bit, slow} = 5'b01000;
    {converter_clock_gate, converter_soft_reset, noise_spread_bit} = 3'b000;
    {trig_req, trigger_always, proc_initiate, phase_offset} = 16'h0000;
    {seq_priority, cmp_enable, cmp_above} = {8'h4e, 8'h0f, 8'hfb};
    {seq_last_step, cmp_threshold} = {12'h018, 12'h000};
    sys_clk_src = ADCSQ_CLK_PLL;
    conv_clk_src = ADCSQ_CLK_PLL;
    {miscompares, comparisons} = 0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    converter_clock_gate <= 1'b1;
    slow <= 1'b1;
    tick(1);
    `CHK({conv_start, result_valid, seq_busy, seq_end, sampling_stalled, cmp_event}, 16'h0000)
    // long seq1, seq0 triggered mid-run must wait; comparator routing
    clear();
    trig(4'h2);
    tick(6);
    trig(4'h1);
    tick(60);
    expect_order({5'h08, 5'h09, 5'h0a, 5'h0b, 5'h00}, 5);
    `CHK(evs, 8'h02)
    `CHK(sus, 2)
    // clock enable first, then the soft reset pulse, so no warm-up flag survives
    @(posedge ref_clk);
    converter_clock_gate <= 1'b0;
    @(posedge ref_clk);
    converter_clock_gate <= 1'b1;
    @(posedge ref_clk);
    converter_soft_reset <= 1'b1;
    @(posedge ref_clk);
    converter_soft_reset <= 1'b0;
    clear();
    trig(4'h1);
    tick(30);
    `CHK(sus, 0)
    // all four pending; seq3 programmed long but runs one step
    clear();
    {slow, noise_spread_bit, seq_last_step} <= {2'b01, 12'he00};
    trig(4'hf);
    tick(40);
    expect_order({5'h10, 5'h18, 5'h00, 5'h08}, 4);
    `CHK(nres, 4)
    clear();
    seq_priority <= 8'h63;
    trig(4'hc);
    tick(30);
    expect_order({5'h10, 5'h18}, 2);
    clear();
    seq_priority <= 8'h9c;
    trig(4'hc);
    tick(30);
    expect_order({5'h18, 5'h10}, 2);
    for (int i = 0; i < 4; i++)
    begin
      clear();
      sys_clk_src <= pair_sys[i];
      conv_clk_src <= pair_conv[i];
      trig(4'h1);
      tick(12);
      `CHK(sampling_stalled, pair_stall[i])
      `CHK(sq.size() == 0, pair_stall[i])
      @(posedge ref_clk);
      sys_clk_src <= ADCSQ_CLK_PLL;
      tick(12);
      `CHK(sq.size(), 1)
    end
    clear();
    trig(4'h1);
    tick(12);
    lat0 = sc[0] - t0;
    clear();
    phase_offset <= 4'h4;
    trig(4'h1);
    tick(16);
    lat4 = sc[0] - t0;
    `CHK(lat4, lat0 + 4)
    // seq1: real steps 0 and 1, dummy step 2 keeps comparator 1 alive
    clear();
    seq_last_step <= 12'h010;
    trig(4'h2);
    tick(24);
    expect_order({5'h08, 5'h09, 5'h0a}, 3);
    `CHK(evs, 8'h0a)
    clear();
    {seq_last_step, trigger_always} <= {12'h008, 4'h2};
    t0 = cyc;
    tick(6);
    @(posedge ref_clk);
    trigger_always <= 4'h0;
    tick(20);
    `CHK(sq.size() > 0 && sc[0] - t0 == lat0, 1'b1)
    `CHK(evs[1], 1'b1)
    clear();
    {phase_offset, sync_wait_bit, proc_initiate} <= {4'h0, 1'b1, 4'h1};
    @(posedge ref_clk);
    proc_initiate <= 4'h2;
    @(posedge ref_clk);
    proc_initiate <= 4'h0;
    tick(10);
    `CHK(sq.size(), 0)
    @(posedge ref_clk);
    global_sync_bit <= 1'b1;
    @(posedge ref_clk);
    {global_sync_bit, sync_wait_bit} <= 2'b00;
    tick(30);
    expect_order({5'h00, 5'h08, 5'h09}, 3);
    // a trigger seen while the clock enable is low must not be taken
    clear();
    clk_en <= 1'b0;
    trig(4'h1);
    tick(6);
    `CHK(sq.size(), 0)
    @(posedge ref_clk);
    clk_en <= 1'b1;
    trig(4'h1);
    tick(12);
    `CHK(sq.size(), 1)
    wrap_up();
  end
endmodule
